/* File: hdl/dmt_dual_timer.sv */
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module dmt_dual_timer
  import dmt_pkg::*;
#(
  parameter int T93US_CYC  = TB_93US_CYC,
  parameter int T1MS_CYC   = TB_1MS_CYC,
  parameter int T10MS_CYC  = TB_10MS_CYC,
  parameter int T100MS_CYC = TB_100MS_CYC,
  parameter int T1S_CYC    = TB_1S_CYC
)
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        clockEnable,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        crystalClock,
  input  wire logic        externalClock,
  input  wire logic        gatePinA,
  input  wire logic        gatePinB,
  output logic             multifunctionOutputPinOut,
  output logic             multifunctionOutputPinOe,
  output logic             interruptRequestPinOut,
  output logic             interruptRequestPinOe
);
  // Per-timer state, index 0 is the first timer
  logic [7:0]  ctl_r    [2];     // Control registers
  logic [15:0] preset_r [2];     // Preset bytes
  logic [15:0] cnt_r    [2];     // Down counters
  logic [15:0] latch_r  [2];     // Counter snapshot for reads
  logic [26:0] div_r    [2];     // Derived time base prescalers
  logic [1:0]  q4_r     [2];     // Crystal quarter prescalers
  logic [1:0]  outQ_r;           // Timer outputs
  logic [1:0]  loaded_r;         // Counter holds a loaded value
  logic [1:0]  pend_r;           // One-shot reload pending
  logic [1:0]  trig_r;           // Previous trigger level
  logic [1:0]  tick;             // Count enables
  logic [1:0]  zeroEv;           // Zero events
  logic [1:0]  hold;             // Suspension request
  logic [1:0]  wrCtl;            // Control write strobes
  logic [1:0]  rdLowDone;        // Low preset byte read completed
  // Register bank and interrupts
  logic        bank_r;           // Selects second block at shared index
  logic [7:0]  cfg_r;            // Output configuration
  logic [7:0]  mask_r;           // Interrupt enables
  logic [7:0]  steer_r;          // Interrupt steering to output pin
  logic [1:0]  status_r;         // Sticky zero flags
  // Synchronisers; the first stage feeds only the second
  logic [1:0]  xtalSync_r;
  logic        xtalPrev_r;
  logic [1:0]  extSync_r;
  logic        extPrev_r;
  logic        xtalFall;
  logic        extFall;
  logic [1:0]  outPrev_r;        // For cascade edge detection
  // Bus decode
  logic [4:0]  idx;
  logic        setup;
  logic        done;
  logic        mapped;
  logic [7:0]  rdByte;
  logic        intLevel;
  logic        mfoLevel;

  assign idx   = paddr[6:2];
  assign setup = psel & ~penable;
  assign done  = psel & penable & pready;

  // Crystal and external clock sync, falling edge as enable
  // RULE_16 two-stage sync
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      xtalSync_r <= 2'h0;
      xtalPrev_r <= 1'b0;
      extSync_r  <= 2'h0;
      extPrev_r  <= 1'b0;
      outPrev_r  <= 2'h0;
    end
    else if (clockEnable)
    begin
      xtalSync_r <= {xtalSync_r[0], crystalClock};
      xtalPrev_r <= xtalSync_r[1];
      extSync_r  <= {extSync_r[0], externalClock};
      extPrev_r  <= extSync_r[1];
      outPrev_r  <= outQ_r;
    end
  end

  // Edge detectors read only the second stage
  assign xtalFall = xtalPrev_r & ~xtalSync_r[1];
  assign extFall  = extPrev_r & ~extSync_r[1];

  // Period of the derived sources in cycles
  function automatic logic [26:0] periodOf(input logic [2:0] sel);
    unique case (dmt_src_e'(sel))
      DMT_SRC_93US:  periodOf = 27'(T93US_CYC);
      DMT_SRC_1MS:   periodOf = 27'(T1MS_CYC);
      DMT_SRC_10MS:  periodOf = 27'(T10MS_CYC);
      DMT_SRC_100MS: periodOf = 27'(T100MS_CYC);
      default:       periodOf = 27'(T1S_CYC);
    endcase
  endfunction

  for (genvar t = 0; t < 2; t++)
  begin : g_tmr
    logic [2:0] sel;
    logic [1:0] mode;
    logic       run;
    logic       srcPulse;
    logic       divEnable;
    logic       doLoad;
    logic       trigRise;
    logic [7:0] lowIdx;

    assign sel  = ctl_r[t][CLOCK_SELECT_BIT0 +: 3];
    assign mode = ctl_r[t][MODE_SELECT_LOW +: 2];
    assign run  = ctl_r[t][TIMER_RUN_BIT];
    assign lowIdx = 8'(IDX_PRESET_A_LOW) + 8'(2 * t);
    // RULE_15 software hold or hardware gate
    assign hold[t] = ctl_r[t][COUNT_HOLD_GATE_BIT] | (t == 0 ? gatePinA : gatePinB);
    assign trigRise = hold[t] & ~trig_r[t];
    // RULE_10 hold only suspends modes 0 to 2
    assign divEnable = run & (~hold[t] | (mode == DMT_ONE_SHOT));

    // RULE_07 clock selection
    always_comb
    begin
      unique case (dmt_src_e'(sel))
        // RULE_08 first timer cascades from the second; the second takes the external clock
        DMT_SRC_CASCADE:   srcPulse = (t == 0) ? (outPrev_r[1] & ~outQ_r[1]) : extFall;
        DMT_SRC_XTAL:      srcPulse = xtalFall;
        DMT_SRC_XTAL_DIV4: srcPulse = xtalFall & (q4_r[t] == 2'(XTAL_DIVIDE - 1));
        default:           srcPulse = (div_r[t] == periodOf(sel) - 27'd1);
      endcase
    end

    // RULE_09 prescaler restarts at start, so error stays below a period
    always_ff @(posedge clock)
    begin
      if (!rst_n)
      begin
        div_r[t] <= 27'h0;
        q4_r[t]  <= 2'h0;
      end
      else if (clockEnable)
      begin
        if (!run)
        begin
          div_r[t] <= 27'h0;
          q4_r[t]  <= 2'h0;
        end
        else if (divEnable)
        begin
          div_r[t] <= (div_r[t] == periodOf(sel) - 27'd1) ? 27'h0 : div_r[t] + 27'd1;
          if (xtalFall)
            q4_r[t] <= q4_r[t] + 2'd1;
        end
      end
    end

    // One-shot counts only while its pulse is live
    assign tick[t] = srcPulse & divEnable
                   & ((mode != DMT_ONE_SHOT) | pend_r[t] | outQ_r[t]);
    assign doLoad  = ~loaded_r[t] | pend_r[t];
    // RULE_11 per-mode zero detection
    always_comb
    begin
      unique case (dmt_mode_e'(mode))
        DMT_RATE_GEN:    zeroEv[t] = tick[t] & ~doLoad & (cnt_r[t] == 16'h1);
        DMT_SQUARE_WAVE: zeroEv[t] = tick[t] & ~doLoad & (cnt_r[t] == 16'h0) & outQ_r[t];
        default:         zeroEv[t] = tick[t] & ~doLoad & (cnt_r[t] <= 16'h1);
      endcase
    end

    assign wrCtl[t]     = done & pwrite & ~bank_r
                        & (idx == (t == 0 ? IDX_TIMER_A_CTL : IDX_TIMER_B_CTL));
    assign rdLowDone[t] = done & ~pwrite & (idx == lowIdx[4:0]);

    // Control register; a software write wins over hardware clears
    always_ff @(posedge clock)
    begin
      if (!rst_n)
      begin
        ctl_r[t]   <= CTL_RESET;
        latch_r[t] <= 16'h0;
      end
      else if (clockEnable)
      begin
        if (wrCtl[t])
        begin
          ctl_r[t] <= pwdata[7:0];
          // RULE_04 snapshot the live count
          if (pwdata[COUNTER_READ_BIT])
            latch_r[t] <= cnt_r[t];
        end
        else
        begin
          // RULE_14 single pulse stops itself
          if (zeroEv[t] && mode == DMT_SINGLE_PULSE)
            ctl_r[t][TIMER_RUN_BIT] <= 1'b0;
          // Reading the low byte ends counter-read
          if (rdLowDone[t])
            ctl_r[t][COUNTER_READ_BIT] <= 1'b0;
        end
      end
    end

    // RULE_01 sixteen-bit down counter and output
    always_ff @(posedge clock)
    begin
      if (!rst_n)
      begin
        cnt_r[t]    <= 16'h0;
        outQ_r[t]   <= 1'b0;
        loaded_r[t] <= 1'b0;
        pend_r[t]   <= 1'b0;
        trig_r[t]   <= 1'b0;
      end
      else if (clockEnable)
      begin
        trig_r[t] <= hold[t];
        // RULE_12 stopped timer holds its output low
        if (!run)
        begin
          outQ_r[t]   <= 1'b0;
          loaded_r[t] <= 1'b0;
          pend_r[t]   <= 1'b0;
        end
        else
        begin
          // Trigger raises the one-shot at once, reload follows
          if (mode == DMT_ONE_SHOT && trigRise)
          begin
            outQ_r[t] <= 1'b1;
            pend_r[t] <= 1'b1;
          end
          if (tick[t])
          begin
            // RULE_06 load both preset bytes
            if (doLoad)
            begin
              cnt_r[t]    <= preset_r[t];
              loaded_r[t] <= 1'b1;
              pend_r[t]   <= 1'b0;
              outQ_r[t]   <= 1'b1;
            end
            else if (mode == DMT_SQUARE_WAVE && cnt_r[t] == 16'h0)
            begin
              cnt_r[t]  <= preset_r[t];
              outQ_r[t] <= ~outQ_r[t];
            end
            else if (mode == DMT_RATE_GEN && cnt_r[t] == 16'h0)
            begin
              cnt_r[t]  <= preset_r[t];
              outQ_r[t] <= 1'b1;
            end
            // RULE_13 output falls on reaching zero
            else if (zeroEv[t])
            begin
              cnt_r[t]  <= 16'h0;
              outQ_r[t] <= 1'b0;
            end
            else if (cnt_r[t] != 16'h0)
              cnt_r[t] <= cnt_r[t] - 16'd1;
          end
        end
      end
    end

    // Mode 0 zero clears the run bit next cycle
    // RULE_14 run self-clears
    chk_single_stop: assert property (@(posedge clock) disable iff (!rst_n)  // RULE_14
      clockEnable && zeroEv[t] && mode == DMT_SINGLE_PULSE && !wrCtl[t]
      |=> !ctl_r[t][TIMER_RUN_BIT])
      else $error("single pulse run bit not cleared");
    // RULE_12
    chk_load_high: assert property (@(posedge clock) disable iff (!rst_n)  // RULE_12
      clockEnable && tick[t] && doLoad && run
      |=> outQ_r[t] && cnt_r[t] == $past(preset_r[t]))
      else $error("load did not raise output with preset");
    // RULE_15
    chk_hold_freeze: assert property (@(posedge clock) disable iff (!rst_n)  // RULE_15
      hold[t] && mode != DMT_ONE_SHOT && run && !wrCtl[t]
      |=> $stable(cnt_r[t]))
      else $error("counter moved while held");
    // RULE_16
    chk_xtal_edge: assert property (@(posedge clock) disable iff (!rst_n)  // RULE_16
      tick[t] && sel == DMT_SRC_XTAL |-> $past(xtalSync_r[1]) && !xtalSync_r[1])
      else $error("crystal tick without falling edge");
    // RULE_04
    chk_read_latch: assert property (@(posedge clock) disable iff (!rst_n)  // RULE_04
      clockEnable && wrCtl[t] && pwdata[COUNTER_READ_BIT]
      |=> latch_r[t] == $past(cnt_r[t]) && ctl_r[t][COUNTER_READ_BIT])
      else $error("counter snapshot wrong");
    cov_pulse_done: cover property (@(posedge clock) disable iff (!rst_n)
      zeroEv[t] && mode == DMT_SINGLE_PULSE);
    cov_retrigger: cover property (@(posedge clock) disable iff (!rst_n)
      mode == DMT_ONE_SHOT && trigRise && outQ_r[t]);
  end

  // RULE_08
  chk_cascade_src: assert property (@(posedge clock) disable iff (!rst_n)  // RULE_08
    tick[0] && ctl_r[0][CLOCK_SELECT_BIT0 +: 3] == 3'(DMT_SRC_CASCADE)
    |-> $past(outQ_r[1]) && !outQ_r[1])
    else $error("cascade tick without second timer fall");
  cov_cascade: cover property (@(posedge clock) disable iff (!rst_n)
    tick[0] && ctl_r[0][CLOCK_SELECT_BIT0 +: 3] == 3'(DMT_SRC_CASCADE));

  // Preset, bank, configuration and steering registers
  // RULE_05 presets are plain storage, usable while stopped
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      preset_r[0] <= PRESET_RESET;
      preset_r[1] <= PRESET_RESET;
      bank_r      <= 1'b0;
      cfg_r       <= CFG_RESET;
      mask_r      <= MASK_RESET;
      steer_r     <= STEER_RESET;
    end
    else if (clockEnable && done && pwrite)
    begin
      unique case (idx)
        IDX_BANK_SELECT:   bank_r <= pwdata[0];
        IDX_PRESET_A_LOW:  preset_r[0][7:0]  <= pwdata[7:0];
        IDX_PRESET_A_HIGH: preset_r[0][15:8] <= pwdata[7:0];
        IDX_PRESET_B_LOW:  preset_r[1][7:0]  <= pwdata[7:0];
        IDX_PRESET_B_HIGH: preset_r[1][15:8] <= pwdata[7:0];
        IDX_OUTPUT_CFG:    if (bank_r) cfg_r <= pwdata[7:0];
        IDX_INT_ENABLE:    if (bank_r) mask_r <= pwdata[7:0];
        IDX_INT_STEER:     if (!bank_r) steer_r <= pwdata[7:0];
        default:           ;
      endcase
    end
  end

  // Sticky zero flags, write one to clear, a new event wins
  // RULE_06 zero sets the interrupt flag
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      status_r <= 2'h0;
    else if (clockEnable)
    begin
      if (done && pwrite && idx == IDX_INT_STATUS)
        status_r <= (status_r & ~pwdata[1:0]) | zeroEv;
      else
        status_r <= status_r | zeroEv;
    end
  end

  chk_zero_flag: assert property (@(posedge clock) disable iff (!rst_n)  // RULE_06
    clockEnable && |zeroEv |=> (status_r & $past(zeroEv)) == $past(zeroEv))
    else $error("zero event lost");

  // Read mux; unmapped indices answer with an error
  always_comb
  begin
    mapped = 1'b1;
    rdByte = 8'h00;
    unique case (idx)
      IDX_BANK_SELECT:   rdByte = {7'h00, bank_r};
      IDX_TIMER_A_CTL:   rdByte = bank_r ? 8'h00 : ctl_r[0];
      IDX_OUTPUT_CFG:    rdByte = bank_r ? cfg_r : ctl_r[1];
      IDX_INT_ENABLE:    rdByte = mask_r;
      IDX_INT_STEER:     rdByte = steer_r;
      IDX_INT_STATUS:    rdByte = {6'h00, status_r};
      // RULE_04 latched count snapshot only while counter-read is set
      IDX_PRESET_A_LOW:  rdByte = ctl_r[0][COUNTER_READ_BIT] ? latch_r[0][7:0] : preset_r[0][7:0];
      IDX_PRESET_A_HIGH: rdByte = ctl_r[0][COUNTER_READ_BIT] ? latch_r[0][15:8] : preset_r[0][15:8];
      IDX_PRESET_B_LOW:  rdByte = ctl_r[1][COUNTER_READ_BIT] ? latch_r[1][7:0] : preset_r[1][7:0];
      IDX_PRESET_B_HIGH: rdByte = ctl_r[1][COUNTER_READ_BIT] ? latch_r[1][15:8] : preset_r[1][15:8];
      default:           mapped = 1'b0;
    endcase
    if ((idx == IDX_TIMER_A_CTL && bank_r) || (idx == IDX_INT_ENABLE && !bank_r)
        || (idx == IDX_INT_STEER && bank_r))
      mapped = 1'b0;
  end

  // APB slave: one wait state, read data captured in setup
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end
    else if (clockEnable)
    begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      if (setup)
        prdata <= (mapped && !pwrite) ? {24'h000000, rdByte} : 32'h0;
    end
  end

  chk_apb_ready: assert property (@(posedge clock) disable iff (!rst_n)
    clockEnable && psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb ready not a single-cycle answer");
  cov_apb_read: cover property (@(posedge clock) disable iff (!rst_n)
    done && !pwrite && ctl_r[0][COUNTER_READ_BIT]);

  // Steered interrupts appear on the multifunction pin instead
  assign intLevel = |(status_r & mask_r[1:0] & ~steer_r[1:0]);
  // RULE_02 only the first timer's output reaches the pin
  assign mfoLevel = |(status_r & mask_r[1:0] & steer_r[1:0]) | outQ_r[0];

  // RULE_03 polarity and drive; open drain only ever pulls low
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      interruptRequestPinOut    <= 1'b0;
      interruptRequestPinOe     <= 1'b0;
      multifunctionOutputPinOut <= 1'b0;
      multifunctionOutputPinOe  <= 1'b0;
    end
    else if (clockEnable)
    begin
      interruptRequestPinOut <= cfg_r[CFG_INTERRUPT_REQUEST_PIN_PUSH_PULL]
                              & ~(intLevel ^ cfg_r[CFG_INTERRUPT_REQUEST_PIN_ACT_HIGH]);
      interruptRequestPinOe  <= cfg_r[CFG_INTERRUPT_REQUEST_PIN_PUSH_PULL]
                              | (intLevel ^ cfg_r[CFG_INTERRUPT_REQUEST_PIN_ACT_HIGH]);
      multifunctionOutputPinOut <= cfg_r[CFG_MFO_PUSH_PULL]
                                 & ~(mfoLevel ^ cfg_r[CFG_MFO_ACT_HIGH]);
      multifunctionOutputPinOe  <= cfg_r[CFG_MFO_PUSH_PULL]
                                 | (mfoLevel ^ cfg_r[CFG_MFO_ACT_HIGH]);
    end
  end

  // RULE_03
  chk_mfo_drive: assert property (@(posedge clock) disable iff (!rst_n)  // RULE_03
    clockEnable && cfg_r[CFG_MFO_PUSH_PULL] && cfg_r[CFG_MFO_ACT_HIGH]
    |=> multifunctionOutputPinOe && multifunctionOutputPinOut == $past(mfoLevel))
    else $error("push-pull output pin wrong");
endmodule
`default_nettype wire

/* File: hdl/dmt_pkg.sv */
// Function
// RULE_01 - Two independent sixteen-bit down counters
// RULE_02 - Only first timer drives the output pin
// RULE_03 - Pins have programmable polarity and drive
// RULE_04 - Preset bytes read unless counter-read set
// RULE_05 - Software configures stopped, then sets run
// RULE_06 - Load presets, count down, act at zero
// RULE_07 - Three-bit field selects one of eight clocks
// RULE_08 - Code zero cascades second timer into first
// RULE_09 - Per-timer prescaler bounds start/hold error
// RULE_10 - Hold gates modes 0-2, triggers mode 3
// RULE_11 - Two-bit field selects one of four modes
// RULE_12 - Single pulse: low stopped, high on load
// RULE_13 - Single pulse stays high until zero
// RULE_14 - Single pulse zero interrupts, clears run
// RULE_15 - Hold bit or gate pin suspends counting
// RULE_16 - Timer clock synchronised, falling edge enables
package dmt_pkg;
  // Register indices; byte address is four times the index
  localparam logic [4:0] IDX_BANK_SELECT   = 5'h00;
  localparam logic [4:0] IDX_TIMER_A_CTL   = 5'h01;
  localparam logic [4:0] IDX_TIMER_B_CTL   = 5'h02;
  localparam logic [4:0] IDX_OUTPUT_CFG    = 5'h02;
  localparam logic [4:0] IDX_INT_ENABLE    = 5'h03;
  localparam logic [4:0] IDX_INT_STEER     = 5'h04;
  localparam logic [4:0] IDX_INT_STATUS    = 5'h05;
  localparam logic [4:0] IDX_PRESET_A_LOW  = 5'h0f;
  localparam logic [4:0] IDX_PRESET_A_HIGH = 5'h10;
  localparam logic [4:0] IDX_PRESET_B_LOW  = 5'h11;
  localparam logic [4:0] IDX_PRESET_B_HIGH = 5'h12;
  // Control register fields
  localparam int TIMER_RUN_BIT       = 0;
  localparam int COUNT_HOLD_GATE_BIT = 1;
  localparam int MODE_SELECT_LOW     = 2;
  localparam int CLOCK_SELECT_BIT0   = 4;
  localparam int COUNTER_READ_BIT    = 7;
  // Output configuration fields
  localparam int CFG_INTERRUPT_REQUEST_PIN_ACT_HIGH   = 0;
  localparam int CFG_INTERRUPT_REQUEST_PIN_PUSH_PULL  = 1;
  localparam int CFG_MFO_ACT_HIGH    = 2;
  localparam int CFG_MFO_PUSH_PULL   = 3;
  // Reset values
  localparam logic [7:0]  CTL_RESET    = 8'h00;
  localparam logic [7:0]  CFG_RESET    = 8'h0f;
  localparam logic [7:0]  MASK_RESET   = 8'h00;
  localparam logic [7:0]  STEER_RESET  = 8'h00;
  localparam logic [15:0] PRESET_RESET = 16'h0000;
  // Clock selections
  typedef enum logic [2:0] {
    DMT_SRC_CASCADE, DMT_SRC_XTAL, DMT_SRC_XTAL_DIV4, DMT_SRC_93US,
    DMT_SRC_1MS, DMT_SRC_10MS, DMT_SRC_100MS, DMT_SRC_1S
  } dmt_src_e;
  typedef enum logic [1:0] {
    DMT_SINGLE_PULSE, DMT_RATE_GEN, DMT_SQUARE_WAVE, DMT_ONE_SHOT
  } dmt_mode_e;
  // Derived time bases, in ns, and cycles at the 10 ns clock
  localparam longint CLOCK_PERIOD_NS = 10;
  localparam longint TB_93US_NS  = 93500;
  localparam longint TB_1MS_NS   = 1000000;
  localparam longint TB_10MS_NS  = 10000000;
  localparam longint TB_100MS_NS = 100000000;
  localparam longint TB_1S_NS    = 1000000000;
  localparam int TB_93US_CYC  = int'(TB_93US_NS / CLOCK_PERIOD_NS);
  localparam int TB_1MS_CYC   = int'(TB_1MS_NS / CLOCK_PERIOD_NS);
  localparam int TB_10MS_CYC  = int'(TB_10MS_NS / CLOCK_PERIOD_NS);
  localparam int TB_100MS_CYC = int'(TB_100MS_NS / CLOCK_PERIOD_NS);
  localparam int TB_1S_CYC    = int'(TB_1S_NS / CLOCK_PERIOD_NS);
  localparam int XTAL_DIVIDE  = 4;
endpackage

/* File: tb/dmt_apb_host.sv */
`timescale 1ns/1ps
`default_nettype none
// Host model: one APB master, one transfer at a time
module dmt_apb_host
(
  input  wire logic        clock,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // Bus idle from time zero
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end

  // Request held until pready seen high at an edge; only then released
  task automatic xfer(input logic w, input logic [4:0] idx, input logic [7:0] d,
                      output logic [7:0] q, output logic e);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {1'b0, idx, 2'b00};
    pwdata  <= {24'h0, d};
    @(posedge clock);
    penable <= 1'b1;
    // No fixed latency assumed; the bench watchdog ends a hang
    do
      @(posedge clock);
    while (pready !== 1'b1);
    q = prdata[7:0];
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: tb/dmt_dual_timer_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module dmt_dual_timer_bench import dmt_pkg::*;;
  logic        clock = 1'b0;  // Design clock
  logic        rst_n;         // Synchronous reset
  logic        psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;         // Byte address
  logic [31:0] pwdata, prdata;
  logic        crystalClock = 1'b0;  // Crystal source
  logic [1:0]  xtalDiv = 2'h0;       // Crystal divider
  logic        gatePinA;      // Gate of first timer
  logic        gatePinB = 1'b0;  // Gate of second timer
  logic        clkEn = 1'b1;     // Design clock enable
  logic [7:0]  q0;            // Earlier read byte
  logic        mfoOut, mfoOe, irqOut, irqOe;
  logic [7:0]  q;             // Last read byte
  logic        e;             // Last error flag
  int          errors = 0;
  int          cmpCount = 0;
  int          cycles = 0;    // Watchdog count
  // Rows: write, index, write data, expected read, expected error
  localparam logic [22:0] ROWS [8] = '{
    {1'b0, IDX_TIMER_A_CTL, 8'h00, CTL_RESET, 1'b0},
    {1'b0, IDX_PRESET_A_LOW, 8'h00, PRESET_RESET[7:0], 1'b0},
    {1'b1, IDX_PRESET_B_HIGH, 8'ha5, 8'h00, 1'b0},
    {1'b0, IDX_PRESET_B_HIGH, 8'h00, 8'ha5, 1'b0},
    {1'b1, IDX_INT_STEER, 8'h00, 8'h00, 1'b0},
    {1'b0, IDX_INT_ENABLE, 8'h00, 8'h00, 1'b1},
    {1'b1, 5'h1f, 8'hff, 8'h00, 1'b1},
    {1'b0, 5'h1f, 8'h00, 8'h00, 1'b1}};

  // Clock of 10 ns period
  always #5 clock = ~clock;

  // Crystal of eight design cycles, free running and unrelated to the bus
  always @(posedge clock)
  begin
    xtalDiv <= xtalDiv + 2'h1;
    if (xtalDiv == 2'h3)
      crystalClock <= ~crystalClock;
  end

  dmt_dual_timer #(.T93US_CYC(20), .T1MS_CYC(30), .T10MS_CYC(40), .T100MS_CYC(50),
    .T1S_CYC(60)) u_dut (.clock(clock), .rst_n(rst_n), .clockEnable(clkEn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .crystalClock(crystalClock), .externalClock(crystalClock),
    .gatePinA(gatePinA), .gatePinB(gatePinB), .multifunctionOutputPinOut(mfoOut),
    .multifunctionOutputPinOe(mfoOe), .interruptRequestPinOut(irqOut),
    .interruptRequestPinOe(irqOe));

  dmt_apb_host u_host (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // Verdict in one place
  task automatic report_and_stop();
    $display("Comparisons %0d mismatches %0d", cmpCount, errors);
    if (errors == 0 && cmpCount > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watchdog; the whole run needs under a thousand cycles
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      errors++;
      report_and_stop();
    end
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmpCount++;
    if (seen !== exp)
    begin
      errors++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [4:0] i, input logic [7:0] d);
    u_host.xfer(1'b1, i, d, q, e);
  endtask

  task automatic rd(input logic [4:0] i);
    u_host.xfer(1'b0, i, 8'h00, q, e);
  endtask

  // Width of first high phase on the pin, eight cycles per crystal tick
  task automatic high_len(input int ticks);
    int n;
    n = 0;
    while (mfoOut !== 1'b1 && n < 400)
    begin
      @(posedge clock);
      n++;
    end
    n = 0;
    while (mfoOut === 1'b1 && n < 400)
    begin
      @(posedge clock);
      n++;
    end
    check("pulse width", 16'(n), 16'(ticks * 8));
  endtask

  initial
  begin
    rst_n    = 1'b0;
    gatePinA = 1'b0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    // Register table: reset values, read-back, refused places
    for (int k = 0; k < 8; k++)
    begin
      u_host.xfer(ROWS[k][22], ROWS[k][21:17], ROWS[k][16:9], q, e);
      if (!ROWS[k][22])
        check("read data", {8'h00, q}, {8'h00, ROWS[k][8:1]});
      check("slave error", {15'h0, e}, {15'h0, ROWS[k][0]});
    end
    // Single pulse of three ticks, held by the gate pin first
    wr(IDX_PRESET_A_LOW, 8'h03);
    wr(IDX_PRESET_A_HIGH, 8'h00);
    wr(IDX_TIMER_A_CTL, 8'h10);
    gatePinA <= 1'b1;
    wr(IDX_TIMER_A_CTL, 8'h11);
    repeat (20) @(posedge clock);
    check("held output", {15'h0, mfoOut}, 16'h0000);
    gatePinA <= 1'b0;
    high_len(3);
    repeat (4) @(posedge clock);
    rd(IDX_TIMER_A_CTL);
    check("run cleared", {8'h00, q}, 16'h0010);
    rd(IDX_INT_STATUS);
    check("status", {8'h00, q}, 16'h0001);
    check("masked irq", {15'h0, irqOut}, 16'h0000);
    wr(IDX_BANK_SELECT, 8'h01);
    wr(IDX_INT_ENABLE, 8'h01);
    wr(IDX_BANK_SELECT, 8'h00);
    check("irq", {15'h0, irqOut}, 16'h0001);
    wr(IDX_INT_STATUS, 8'h01);
    repeat (3) @(posedge clock);
    check("irq cleared", {15'h0, irqOut}, 16'h0000);
    // Rate generator high for N ticks, square wave for N+1
    for (int m = 1; m < 3; m++)
    begin
      wr(IDX_TIMER_A_CTL, 8'h10 | 8'(m << 2));
      wr(IDX_TIMER_A_CTL, 8'h11 | 8'(m << 2));
      high_len(m == 2 ? 4 : 3);
      wr(IDX_TIMER_A_CTL, 8'h10);
    end
    // Live count of second timer, then presets again
    wr(IDX_PRESET_B_LOW, 8'h00);
    wr(IDX_PRESET_B_HIGH, 8'h01);
    wr(IDX_TIMER_B_CTL, 8'h10);
    wr(IDX_TIMER_B_CTL, 8'h11);
    repeat (40) @(posedge clock);
    wr(IDX_TIMER_B_CTL, 8'h91);
    rd(IDX_PRESET_B_HIGH);
    check("count high", {8'h00, q}, 16'h0000);
    rd(IDX_PRESET_B_LOW);
    check("count low zero", {15'h0, q == 8'h00}, 16'h0000);
    rd(IDX_PRESET_B_LOW);
    check("preset low", {8'h00, q}, 16'h0000);
    check("pin idle", {15'h0, mfoOut}, 16'h0000);
    // Gate pin of the second timer freezes its count
    gatePinB <= 1'b1;
    wr(IDX_TIMER_B_CTL, 8'h91);
    rd(IDX_PRESET_B_LOW);
    q0 = q;
    repeat (40) @(posedge clock);
    wr(IDX_TIMER_B_CTL, 8'h91);
    rd(IDX_PRESET_B_LOW);
    check("gate b hold", {8'h00, q}, {8'h00, q0});
    gatePinB <= 1'b0;
    // Cascade: second timer falls every two ticks, first pulse of three falls
    wr(IDX_PRESET_B_LOW, 8'h01);
    wr(IDX_PRESET_B_HIGH, 8'h00);
    wr(IDX_TIMER_B_CTL, 8'h14);
    wr(IDX_TIMER_B_CTL, 8'h15);
    wr(IDX_TIMER_A_CTL, 8'h00);
    wr(IDX_TIMER_A_CTL, 8'h01);
    high_len(6);
    wr(IDX_TIMER_B_CTL, 8'h10);
    // One-shot triggered by a gate pin rise
    wr(IDX_TIMER_A_CTL, 8'h1c);
    wr(IDX_TIMER_A_CTL, 8'h1d);
    gatePinA <= 1'b1;
    repeat (8) @(posedge clock);
    check("trigger", {15'h0, mfoOut}, 16'h0001);
    repeat (16) @(posedge clock);
    check("shot high", {15'h0, mfoOut}, 16'h0001);
    repeat (24) @(posedge clock);
    check("shot end", {15'h0, mfoOut}, 16'h0000);
    // Trigger while the clock enable is low waits for the enable
    gatePinA <= 1'b0;
    repeat (2) @(posedge clock);
    clkEn    <= 1'b0;
    gatePinA <= 1'b1;
    repeat (40) @(posedge clock);
    check("frozen", {15'h0, mfoOut}, 16'h0000);
    clkEn <= 1'b1;
    repeat (8) @(posedge clock);
    check("late trigger", {15'h0, mfoOut}, 16'h0001);
    repeat (48) @(posedge clock);
    // Open drain lets go when inactive; active low drives high
    wr(IDX_INT_STATUS, 8'h03);
    wr(IDX_BANK_SELECT, 8'h01);
    wr(IDX_OUTPUT_CFG, 8'h00);
    repeat (3) @(posedge clock);
    check("drain enables", {14'h0, mfoOe, irqOe}, 16'h0000);
    wr(IDX_OUTPUT_CFG, 8'h08);
    repeat (3) @(posedge clock);
    check("active low", {14'h0, mfoOut, mfoOe}, 16'h0003);
    report_and_stop();
  end
endmodule
`default_nettype wire
